// file: verilog/rsc_top.sv
`include "rsc_defines.svh"

module rsc_top #(
    parameter int unsigned MCD_TIMEOUT_CYCLES = `RSC_MCD_CYCLES,
    parameter int unsigned POR_DELAY_CYCLES   = `RSC_POR_DELAY_CYCLES
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   s_axi_awvalid,
    output      logic                   s_axi_awready,
    input  wire logic [11:0]            s_axi_awaddr,
    input  wire logic [2:0]             s_axi_awprot,
    input  wire logic                   s_axi_wvalid,
    output      logic                   s_axi_wready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    output      logic                   s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    output      logic [1:0]             s_axi_bresp,
    input  wire logic                   s_axi_arvalid,
    output      logic                   s_axi_arready,
    input  wire logic [11:0]            s_axi_araddr,
    input  wire logic [2:0]             s_axi_arprot,
    output      logic                   s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    output      logic [31:0]            s_axi_rdata,
    output      logic [1:0]             s_axi_rresp,
    input  wire logic                   rst_pin_n_in,
    output      logic                   rst_pin_out,
    output      logic                   rst_pin_oe,
    input  wire logic                   vdd_above_low,
    input  wire logic                   vdd_above_high,
    input  wire logic                   vdm_settled,
    input  wire logic                   cmp_pos_above_neg,
    input  wire logic                   system_clock_probe,
    input  wire logic                   wdt_timeout,
    input  wire logic                   flash_write_req,
    input  wire logic                   flash_illegal_access,
    output      rsc_pkg::rsc_core_ctrl_t core_ctrl
);

    localparam logic [15:0] MCD_LAST = 16'(MCD_TIMEOUT_CYCLES - 1);
    localparam logic [15:0] POR_LAST = 16'(POR_DELAY_CYCLES - 1);

    rsc_pkg::rsc_state_t st_ff;
    rsc_pkg::rsc_state_t nxt_st;

    // ************************************************************
    // combinational helpers
    // ************************************************************
    logic       supply_ok;
    logic       vdm_low;
    logic [7:0] cause_now;
    logic [7:0] cause_rd;
    logic [7:0] smc_rd;
    logic       in_reset;

    always_comb begin
        supply_ok = st_ff.vdm_thr ? vdd_above_high : vdd_above_low;
        // an enabled monitor selected as a source that is not settled counts as low
        vdm_low   = st_ff.vdm_src & st_ff.vdm_en & ~(vdm_settled & supply_ok);
        in_reset  = (st_ff.fsm != rsc_pkg::RSC_ST_RUN);
        cause_now = 8'h00;
        cause_now[`RSC_BIT_PIN]   = ~st_ff.pin_s2 & ~st_ff.pin_oe;
        cause_now[`RSC_BIT_POR]   = vdm_low;
        cause_now[`RSC_BIT_MCD]   = st_ff.mcd_en & (st_ff.mcd_cnt == MCD_LAST);
        cause_now[`RSC_BIT_WDT]   = wdt_timeout;
        cause_now[`RSC_BIT_SOFT]  = st_ff.soft_req;
        cause_now[`RSC_BIT_CMP]   = st_ff.cmp_en & ~st_ff.cmp_s2;
        cause_now[`RSC_BIT_FLASH] = flash_illegal_access
            | (flash_write_req & ~(st_ff.vdm_en & st_ff.vdm_thr & st_ff.vdm_src));
        // read shows cause flags, bit 7 always zero
        cause_rd = {1'b0, st_ff.flags[6:0]};
        smc_rd   = 8'h00;
        smc_rd[`RSC_BIT_SMC_EN]   = st_ff.vdm_en;
        smc_rd[`RSC_BIT_SMC_STAT] = supply_ok;
        smc_rd[`RSC_BIT_SMC_THR]  = st_ff.vdm_thr;
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        nxt_st = st_ff;

        // two-stage synchronisers for pin and comparator
        // own pin drive is sampled as high, so its read-back never looks external
        nxt_st.pin_s1 = rst_pin_n_in | st_ff.pin_oe;
        nxt_st.pin_s2 = st_ff.pin_s1;
        nxt_st.cmp_s1 = cmp_pos_above_neg;
        nxt_st.cmp_s2 = st_ff.cmp_s1;

        // clock-loss detector: count cycles the probed clock level stays put
        nxt_st.mcd_last = system_clock_probe;
        if (!st_ff.mcd_en || in_reset || (system_clock_probe != st_ff.mcd_last)) begin
            nxt_st.mcd_cnt = 16'h0000;
        end else if (st_ff.mcd_cnt != MCD_LAST) begin
            nxt_st.mcd_cnt = st_ff.mcd_cnt + 16'h0001;
        end

        nxt_st.soft_req        = 1'b0;
        nxt_st.ctrl.exit_pulse = 1'b0;
        nxt_st.ctrl.ram_clear  = 1'b0;

        // ************************************************************
        // reset sequencing
        // ************************************************************
        unique case (st_ff.fsm)
            rsc_pkg::RSC_ST_POR_WAIT: begin
                nxt_st.pin_oe    = 1'b1;
                nxt_st.delay_cnt = 16'h0000;
                if (supply_ok) begin
                    nxt_st.fsm = rsc_pkg::RSC_ST_POR_DELAY;
                end
            end
            rsc_pkg::RSC_ST_POR_DELAY: begin
                nxt_st.pin_oe = 1'b1;
                if (!supply_ok) begin
                    nxt_st.fsm = rsc_pkg::RSC_ST_POR_WAIT;
                end else if (st_ff.delay_cnt == POR_LAST) begin
                    nxt_st.pend = 8'h00;
                    nxt_st.pend[`RSC_BIT_POR] = 1'b1;
                    nxt_st.fsm  = rsc_pkg::RSC_ST_EXIT;
                end else begin
                    nxt_st.delay_cnt = st_ff.delay_cnt + 16'h0001;
                end
            end
            rsc_pkg::RSC_ST_RUN: begin
                if (cause_now != 8'h00) begin
                    nxt_st.pend   = cause_now;
                    nxt_st.pin_oe = vdm_low;
                    nxt_st.cmp_en = 1'b0;
                    nxt_st.mcd_en = 1'b0;
                    nxt_st.fsm    = rsc_pkg::RSC_ST_RESET;
                end
            end
            rsc_pkg::RSC_ST_RESET: begin
                // later causes accumulate; own pin drive is not an external pin reset
                nxt_st.pend   = st_ff.pend | cause_now;
                nxt_st.pin_oe = vdm_low;
                if (!vdm_low && st_ff.pin_s2) begin
                    // supply-monitor exit skips the power-on delay
                    nxt_st.fsm    = rsc_pkg::RSC_ST_EXIT;
                    nxt_st.pin_oe = 1'b0;
                end
            end
            rsc_pkg::RSC_ST_EXIT: begin
                nxt_st.pin_oe          = 1'b0;
                // power-on bit survives only a power-on or monitor reset
                nxt_st.flags           = {1'b0, st_ff.pend[6:0]};
                nxt_st.ctrl.exit_pulse = 1'b1;
                nxt_st.ctrl.clk_internal = 1'b1;
                nxt_st.ctrl.wdt_enable = 1'b1;
                nxt_st.ctrl.wdt_div    = `RSC_WDT_DIV;
                nxt_st.ctrl.start_addr = `RSC_START_ADDR;
                nxt_st.fsm             = rsc_pkg::RSC_ST_RUN;
            end
        endcase

        // core hold outputs follow the next state; port latch and open-drain are only forced in reset, weak pull-up is always on
        nxt_st.ctrl.core_halt        = (nxt_st.fsm != rsc_pkg::RSC_ST_RUN);
        nxt_st.ctrl.sfr_init         = (nxt_st.fsm != rsc_pkg::RSC_ST_RUN);
        nxt_st.ctrl.sp_reinit        = (nxt_st.fsm != rsc_pkg::RSC_ST_RUN);
        nxt_st.ctrl.irq_timer_off    = (nxt_st.fsm != rsc_pkg::RSC_ST_RUN);
        if (nxt_st.fsm != rsc_pkg::RSC_ST_RUN) begin
            nxt_st.ctrl.port_latch      = `RSC_PORT_LATCH_RST;
            nxt_st.ctrl.port_open_drain = 1'b1;
        end
        nxt_st.ctrl.port_weak_pullup = 1'b1;

        // ************************************************************
        // register bus, write path
        // ************************************************************
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_held = 1'b1;
            nxt_st.aw_idx  = s_axi_awaddr[11:2];
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_held  = 1'b1;
            nxt_st.w_data  = s_axi_wdata[7:0];
            nxt_st.w_lane0 = s_axi_wstrb[0];
        end
        if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = `RSC_RESP_SLVERR;
            if (st_ff.aw_idx == `RSC_CAUSE_IDX) begin
                nxt_st.bresp = `RSC_RESP_OKAY;
                if (st_ff.w_lane0 && !in_reset) begin
                    // writes set enables, they never touch the flags
                    nxt_st.cmp_en   = st_ff.w_data[`RSC_BIT_CMP];
                    nxt_st.mcd_en   = st_ff.w_data[`RSC_BIT_MCD];
                    nxt_st.vdm_src  = st_ff.w_data[`RSC_BIT_POR];
                    nxt_st.soft_req = st_ff.w_data[`RSC_BIT_SOFT];
                end
            end else if (st_ff.aw_idx == `RSC_SMC_IDX) begin
                nxt_st.bresp = `RSC_RESP_OKAY;
                if (st_ff.w_lane0 && !in_reset) begin
                    nxt_st.vdm_en  = st_ff.w_data[`RSC_BIT_SMC_EN];
                    nxt_st.vdm_thr = st_ff.w_data[`RSC_BIT_SMC_THR];
                end
            end
        end
        nxt_st.awready = ~nxt_st.aw_held;
        nxt_st.wready  = ~nxt_st.w_held;

        // ************************************************************
        // register bus, read path
        // ************************************************************
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata  = 32'h0000_0000;
            nxt_st.rresp  = `RSC_RESP_OKAY;
            if (s_axi_araddr[11:2] == `RSC_CAUSE_IDX) begin
                nxt_st.rdata[7:0] = cause_rd;
            end else if (s_axi_araddr[11:2] == `RSC_SMC_IDX) begin
                nxt_st.rdata[7:0] = smc_rd;
            end else begin
                nxt_st.rresp = `RSC_RESP_SLVERR;
            end
        end
        nxt_st.arready = ~nxt_st.rvalid;
    end

    // ************************************************************
    // state register; bus reset is the power-on event
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff.fsm       <= rsc_pkg::RSC_ST_POR_WAIT;
            st_ff.delay_cnt <= 16'h0000;
            st_ff.mcd_cnt   <= 16'h0000;
            st_ff.mcd_last  <= 1'b0;
            st_ff.pin_s1    <= 1'b1;
            st_ff.pin_s2    <= 1'b1;
            st_ff.cmp_s1    <= 1'b1;
            st_ff.cmp_s2    <= 1'b1;
            st_ff.flags     <= 8'h00;
            st_ff.pend      <= 8'h00;
            st_ff.vdm_en    <= `RSC_SMC_EN_POR;
            st_ff.vdm_thr   <= `RSC_SMC_THR_POR;
            st_ff.vdm_src   <= `RSC_VDM_SRC_POR;
            st_ff.cmp_en    <= 1'b0;
            st_ff.mcd_en    <= 1'b0;
            st_ff.pin_oe    <= 1'b1;
            st_ff.soft_req  <= 1'b0;
            st_ff.ctrl.core_halt        <= 1'b1;
            st_ff.ctrl.sfr_init         <= 1'b1;
            st_ff.ctrl.sp_reinit        <= 1'b1;
            st_ff.ctrl.ram_clear        <= 1'b0;
            st_ff.ctrl.irq_timer_off    <= 1'b1;
            st_ff.ctrl.port_latch       <= `RSC_PORT_LATCH_RST;
            st_ff.ctrl.port_open_drain  <= 1'b1;
            st_ff.ctrl.port_weak_pullup <= 1'b1;
            st_ff.ctrl.exit_pulse       <= 1'b0;
            st_ff.ctrl.clk_internal     <= 1'b1;
            st_ff.ctrl.wdt_enable       <= 1'b1;
            st_ff.ctrl.wdt_div          <= `RSC_WDT_DIV;
            st_ff.ctrl.start_addr       <= `RSC_START_ADDR;
            st_ff.aw_held   <= 1'b0;
            st_ff.aw_idx    <= 10'h000;
            st_ff.w_held    <= 1'b0;
            st_ff.w_data    <= 8'h00;
            st_ff.w_lane0   <= 1'b0;
            st_ff.awready   <= 1'b0;
            st_ff.wready    <= 1'b0;
            st_ff.bvalid    <= 1'b0;
            st_ff.bresp     <= `RSC_RESP_OKAY;
            st_ff.arready   <= 1'b0;
            st_ff.rvalid    <= 1'b0;
            st_ff.rdata     <= 32'h0000_0000;
            st_ff.rresp     <= `RSC_RESP_OKAY;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ************************************************************
    // outputs, all straight from the state register except the constant rst_pin_out
    // ************************************************************
    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready  = st_ff.wready;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign s_axi_rdata   = st_ff.rdata;
    assign s_axi_rresp   = st_ff.rresp;
    // open-drain: the pin is only ever pulled low
    assign rst_pin_out   = 1'b0;
    assign rst_pin_oe    = st_ff.pin_oe;
    assign core_ctrl     = st_ff.ctrl;

endmodule : rsc_top

// file: common/rsc_defines.svh
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

// register indices, byte address is four times the index
`define RSC_CAUSE_IDX        10'h0ef
`define RSC_SMC_IDX          10'h0ff

// reset cause register bit positions
`define RSC_BIT_FLASH        6
`define RSC_BIT_CMP          5
`define RSC_BIT_SOFT         4
`define RSC_BIT_WDT          3
`define RSC_BIT_MCD          2
`define RSC_BIT_POR          1
`define RSC_BIT_PIN          0

// supply monitor control bit positions
`define RSC_BIT_SMC_EN       7
`define RSC_BIT_SMC_STAT     6
`define RSC_BIT_SMC_THR      5

// reset values
`define RSC_SMC_EN_POR       1'b1
`define RSC_SMC_THR_POR      1'b0
`define RSC_VDM_SRC_POR      1'b1
`define RSC_PORT_LATCH_RST   8'hff
`define RSC_START_ADDR       16'h0000
`define RSC_WDT_DIV          4'hc

// timing
`define RSC_CLK_PERIOD_NS    10
`define RSC_MCD_TIMEOUT_NS   100000
`define RSC_MCD_CYCLES       ((`RSC_MCD_TIMEOUT_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_POR_DELAY_CYCLES 64

// bus answers
`define RSC_RESP_OKAY        2'b00
`define RSC_RESP_SLVERR      2'b10

`endif

// file: common/rsc_pkg.sv
package rsc_pkg;

    typedef enum logic [4:0] {
        RSC_ST_POR_WAIT  = 5'b00001,
        RSC_ST_POR_DELAY = 5'b00010,
        RSC_ST_RUN       = 5'b00100,
        RSC_ST_RESET     = 5'b01000,
        RSC_ST_EXIT      = 5'b10000
    } rsc_fsm_t;

    typedef struct packed {
        logic        core_halt;
        logic        sfr_init;
        logic        sp_reinit;
        logic        ram_clear;
        logic        irq_timer_off;
        logic [7:0]  port_latch;
        logic        port_open_drain;
        logic        port_weak_pullup;
        logic        exit_pulse;
        logic        clk_internal;
        logic        wdt_enable;
        logic [3:0]  wdt_div;
        logic [15:0] start_addr;
    } rsc_core_ctrl_t;

    typedef struct packed {
        rsc_fsm_t       fsm;
        logic [15:0]    delay_cnt;
        logic [15:0]    mcd_cnt;
        logic           mcd_last;
        logic           pin_s1;
        logic           pin_s2;
        logic           cmp_s1;
        logic           cmp_s2;
        logic [7:0]     flags;
        logic [7:0]     pend;
        logic           vdm_en;
        logic           vdm_thr;
        logic           vdm_src;
        logic           cmp_en;
        logic           mcd_en;
        logic           pin_oe;
        logic           soft_req;
        rsc_core_ctrl_t ctrl;
        logic           aw_held;
        logic [9:0]     aw_idx;
        logic           w_held;
        logic [7:0]     w_data;
        logic           w_lane0;
        logic           awready;
        logic           wready;
        logic           bvalid;
        logic [1:0]     bresp;
        logic           arready;
        logic           rvalid;
        logic [31:0]    rdata;
        logic [1:0]     rresp;
    } rsc_state_t;

endpackage : rsc_pkg

// file: dv/rsc_partner.sv
module rsc_partner #(
    parameter int LOW_MV  = 1800,
    parameter int HIGH_MV = 2400
) (
    input  wire logic aclk,
    input  wire logic ext_low,
    input  wire logic drive_oe,
    input  wire logic drive_val,
    input  wire logic clk_run,
    input  var  int   vdd_mv,
    input  var  int   pos_mv,
    input  var  int   neg_mv,
    output      logic pin_n,
    output      logic above_low,
    output      logic above_high,
    output      logic cmp_out,
    output      logic probe
);
    timeunit 1ns;
    timeprecision 1ps;
    // pin has a pull-up; either side may pull it low
    assign pin_n      = !ext_low && !(drive_oe && !drive_val);
    assign above_low  = vdd_mv >= LOW_MV;
    assign above_high = vdd_mv >= HIGH_MV;
    assign cmp_out    = pos_mv >= neg_mv;
    initial probe = 1'b0;
    always @(posedge aclk) if (clk_run) probe <= !probe;
endmodule : rsc_partner

// file: dv/rsc_checker.sv
module rsc_checker (
    input wire logic                    aclk,
    input wire logic                    aresetn,
    input wire logic                    rst_pin_n_in,
    input wire logic                    rst_pin_out,
    input wire logic                    rst_pin_oe,
    input wire logic                    wdt_timeout,
    input wire logic                    flash_illegal_access,
    input wire rsc_pkg::rsc_core_ctrl_t core_ctrl
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire h = core_ctrl.core_halt;
    sequence halt_seq;
        ##[1:6] core_ctrl.core_halt;
    endsequence
    core_hold_a: assert property (h |-> core_ctrl.sfr_init && core_ctrl.sp_reinit
        && core_ctrl.irq_timer_off) else $error("core not held in reset");
    mem_keep_a: assert property (!core_ctrl.ram_clear) else $error("memory cleared");
    port_safe_a: assert property (h |-> core_ctrl.port_latch == 8'hff
        && core_ctrl.port_open_drain && core_ctrl.port_weak_pullup) else $error("port state");
    pin_drive_a: assert property (rst_pin_oe |-> h && rst_pin_out == 1'b0)
        else $error("pin driven outside reset");
    exit_state_a: assert property ($fell(h) |-> core_ctrl.exit_pulse && core_ctrl.clk_internal
        && core_ctrl.wdt_enable && core_ctrl.wdt_div == 4'hc && core_ctrl.start_addr == 16'h0000)
        else $error("exit state wrong");
    por_hold_a: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> rst_pin_oe && h)
        else $error("power-on hold missing");
    pin_rst_a: assert property ($fell(rst_pin_n_in) && !rst_pin_oe && !h |-> halt_seq)
        else $error("pin reset missing");
    wdt_rst_a: assert property (wdt_timeout && !h |-> halt_seq ##0 !rst_pin_oe)
        else $error("watchdog reset wrong");
    flash_rst_a: assert property (flash_illegal_access && !h |-> halt_seq ##0 !rst_pin_oe)
        else $error("flash error reset wrong");
endmodule : rsc_checker
bind rsc_top rsc_checker rsc_checker_i (.aclk(aclk), .aresetn(aresetn), .rst_pin_n_in(rst_pin_n_in),
    .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .wdt_timeout(wdt_timeout),
    .flash_illegal_access(flash_illegal_access), .core_ctrl(core_ctrl));

// file: dv/rsc_top_test.sv
`include "rsc_defines.svh"
`define CK(n, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module rsc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] CA = {`RSC_CAUSE_IDX, 2'b00};
    localparam logic [11:0] SA = {`RSC_SMC_IDX, 2'b00};
    localparam int          PD = 40;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic ext_low = 0, clk_run = 1, vdm_ok = 1;
    logic [2:0]  pz = 0;
    logic [11:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat;
    logic [1:0]  rresp, bres;
    int          vdd = 1000, pos = 1000, neg = 500, checks = 0, error_cnt = 0, len;
    wire         awr, wrr, bv, arr, rv, pin_n, po, poe, alo, ahi, cmp, probe;
    wire [1:0]   br, rr;
    wire [31:0]  rdd;
    rsc_pkg::rsc_core_ctrl_t cc;
    rsc_top #(.MCD_TIMEOUT_CYCLES(20), .POR_DELAY_CYCLES(PD)) rsc_top_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdd),
        .s_axi_rresp(rr), .rst_pin_n_in(pin_n), .rst_pin_out(po), .rst_pin_oe(poe),
        .vdd_above_low(alo), .vdd_above_high(ahi), .vdm_settled(vdm_ok),
        .cmp_pos_above_neg(cmp), .system_clock_probe(probe), .wdt_timeout(pz[0]),
        .flash_write_req(pz[1]), .flash_illegal_access(pz[2]), .core_ctrl(cc));
    rsc_partner rsc_partner_i (.aclk(aclk), .ext_low(ext_low), .drive_oe(poe), .drive_val(po),
        .clk_run(clk_run), .vdd_mv(vdd), .pos_mv(pos), .neg_mv(neg), .pin_n(pin_n),
        .above_low(alo), .above_high(ahi), .cmp_out(cmp), .probe(probe));
    always #5 aclk = !aclk;
    // ********
    // bus cycles
    // ********
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        awv <= 1;
        wv <= 1;
        awa <= a;
        wd <= {24'h0, d};
        bry <= 1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 0;
            if (wrr) wv <= 0;
        end while (!bv);
        bres = br;
        bry <= 0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        arv <= 1;
        ara <= a;
        rry <= 1;
        do begin
            @(posedge aclk);
            if (arr) arv <= 0;
        end while (!rv);
        rdat = rdd;
        rresp = rr;
        rry <= 0;
        @(posedge aclk);
    endtask : rd
    // follows one reset to its end, then reads the cause
    task automatic ride(input logic [7:0] cause, input logic oe_exp);
        logic o;
        o = 0;
        len = 0;
        while (cc.core_halt !== 1'b1 && len < 30) @(posedge aclk) len++;
        len = 0;
        while (cc.core_halt !== 1'b0 && len < 300) begin
            o = o | poe;
            @(posedge aclk);
            len++;
        end
        rd(CA);
        `CK("cause", {24'h0, cause}, rdat)
        `CK("pin_drive", oe_exp, o)
    endtask : ride
    task automatic pulse(input int k, input logic [7:0] c);
        pz[k] <= 1;
        @(posedge aclk);
        pz <= 0;
        ride(c, 1'b0);
    endtask : pulse
    // ********
    // scenarios
    // ********
    task automatic t_por;
        repeat (5) @(posedge aclk);
        `CK("por_pin", 1'b1, poe)
        vdd <= 3300;
        ride(8'h02, 1'b1);
        `CK("por_delay", 1'b1, len >= PD)
        rd(SA);
        `CK("smc", 32'hc0, rdat)
    endtask : t_por
    task automatic t_sources;
        pulse(0, 8'h08);
        pulse(2, 8'h40);
        wr(CA, 8'h12);
        ride(8'h10, 1'b0);
        ext_low <= 1;
        repeat (10) @(posedge aclk);
        ext_low <= 0;
        ride(8'h01, 1'b0);
        wr(CA, 8'h22);
        pos <= 0;
        repeat (6) @(posedge aclk);
        pos <= 1000;
        ride(8'h20, 1'b0);
        wr(CA, 8'h06);
        clk_run <= 0;
        repeat (30) @(posedge aclk);
        clk_run <= 1;
        ride(8'h04, 1'b0);
    endtask : t_sources
    task automatic t_vdm;
        vdd <= 1000;
        repeat (5) @(posedge aclk);
        `CK("vdm_pin", 1'b1, poe)
        vdd <= 3300;
        ride(8'h02, 1'b1);
        `CK("vdm_fast", 1'b1, len < PD)
        wr(SA, 8'h00);
        wr(CA, 8'h10);
        ride(8'h10, 1'b0);
        rd(SA);
        `CK("smc_kept", 1'b0, rdat[7])
        // monitor enabled but not settled: selecting it as a source resets
        vdm_ok <= 0;
        wr(SA, 8'ha0);
        wr(CA, 8'h02);
        repeat (3) @(posedge aclk);
        vdm_ok <= 1;
        ride(8'h02, 1'b1);
        pz[1] <= 1;
        @(posedge aclk);
        pz <= 0;
        repeat (5) @(posedge aclk);
        `CK("flash_ok", 1'b0, cc.core_halt)
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        ride(8'h02, 1'b1);
        rd(SA);
        `CK("smc_por", 32'hc0, rdat)
        pulse(1, 8'h40);
        wr(12'h010, 8'h00);
        `CK("wr_unmapped", `RSC_RESP_SLVERR, bres)
        rd(12'h010);
        `CK("rd_unmapped", {`RSC_RESP_SLVERR, 32'h0}, {rresp, rdat})
    endtask : t_vdm
    task automatic complete_run;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        t_por();
        t_sources();
        t_vdm();
        complete_run();
    end
    initial begin
        #100000;
        error_cnt++;
        complete_run();
    end
endmodule : rsc_top_test
